/* File: rtl/hab_base_reg.sv */
// one base-address register with size-dependent writable bits
`timescale 1ns/1ps
`default_nettype none
module hab_base_reg (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] mask_i,
  output logic      [31:0] base_o
);
  import hab_pkg::*;
  logic [31:0] base_r;
  logic [31:0] base_nxt;

  always_comb begin
    base_nxt = wr_i ? (wdata_i & mask_i) : base_r;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_r <= BASE_RESET;
    end else begin
      base_r <= base_nxt;
    end
  end

  // all-ones write reads back as the mask: msb-aligned ones, zeros below
  assign base_o = base_r & mask_i;
endmodule : hab_base_reg
`default_nettype wire

/* File: rtl/hab_boot.sv */
// boot loader, aperture sizing registers and core reset control
// Functional notes
// - stage one loads subsystem ids, memory config and clock multipliers, waits for lock, enables highway and memory interface, core stays in reset.
// - after stage one the configuration port answers and the serial interface is released.
// - exactly two base registers exist, one for the register aperture and one for sdram.
// - the register aperture is 2 MB, so an all-ones write reads back as 0xFFE00000.
// - the sdram aperture is a power of two from 1 MB to 64 MB, following the configured size.
// - a base register written with all ones reads back msb-aligned ones in the significant bits and zeros below.
// - after configuration the device answers configuration accesses while the core stays in reset.
// - in autonomous boot both base registers are copied from the eeprom.
// - host-assisted boot reads eeprom lines zero to nine only.
// - line zero gives the row setting and the memory size code.
// - multi-byte words are assembled from consecutive bytes with no alignment assumed.
// - line nine bit seven selects host-assisted (0) or autonomous (1) boot.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hab_boot (
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // eeprom byte reader on the same clock
  output logic                       ee_req_o,
  output logic                [10:0] ee_addr_o,
  input  wire logic                  ee_ack_i,
  input  wire logic           [7:0]  ee_data_i,
  // pll lock pin
  input  wire logic                  pll_lock_i,
  // configuration port
  input  wire logic           [7:0]  cfg_addr_i,
  input  wire logic           [31:0] cfg_wdata_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  output logic                [31:0] cfg_rdata_o,
  // system controls
  output hab_pkg::hab_boot_cfg_s     boot_cfg_o,
  output logic                       highway_en_o,
  output logic                       mem_if_en_o,
  output logic                       core_reset_o,
  output logic                       cfg_ready_o,
  output logic                       serial_release_o,
  output logic                [31:0] register_aperture_base_o,
  output logic                [31:0] sdram_aperture_base_o
);
  import hab_pkg::*;

  hab_state_e    state_r;
  hab_state_e    state_nxt;
  logic [10:0]   line_r;
  logic [10:0]   line_nxt;
  logic [10:0]   last_r;
  logic [10:0]   last_nxt;
  hab_boot_cfg_s cfg_r;
  hab_boot_cfg_s cfg_nxt;
  logic          cap_r;
  logic          cap_nxt;
  logic [10:0]   cap_line_r;
  logic [10:0]   cap_line_nxt;
  logic          hwy_r;
  logic          hwy_nxt;
  logic          ready_r;
  logic          ready_nxt;
  logic          run_r;
  logic          run_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic          lock_s1_r;
  logic          lock_s2_r;
  logic [31:0]   word;
  logic [31:0]   sdrap_mask;
  logic          bar0_wr;
  logic          bar1_wr;
  logic [31:0]   bar_wdata;
  logic [31:0]   bar0_q;
  logic [31:0]   bar1_q;
  logic          acc_wr;
  logic          acc_rd;

  // lock pin enters through two flops
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= pll_lock_i;
      lock_s2_r <= lock_s1_r;
    end
  end

  // every accepted byte shifts in; word captures follow one cycle after the last byte
  hab_byte_asm u_asm (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .push_i     (ee_req_o && ee_ack_i),
    .byte_i     (ee_data_i),
    .word_o     (word)
  );

  // size code 0 and 1 give 1 MB, code 7 gives 64 MB
  // the mask is applied on read too, so a later size change re-masks a stored base
  always_comb begin
    if (cfg_r.mem_size_code == 3'h0) begin
      sdrap_mask = SDRAP_MASK_1MB;
    end else begin
      sdrap_mask = SDRAP_MASK_1MB << (cfg_r.mem_size_code - 3'h1);
    end
  end

  // configuration space is dead until stage one has finished
  // writes that arrive earlier are dropped, not queued
  assign acc_wr = cfg_wr_i && ready_r;
  assign acc_rd = cfg_rd_i && ready_r;

  // eeprom copy wins over a bus write; none can coincide since the bus is closed then
  always_comb begin
    bar0_wr   = 1'b0;
    bar1_wr   = 1'b0;
    bar_wdata = cfg_wdata_i;
    if (cap_r && cap_line_r == LINE_REGAP_LAST) begin
      bar0_wr   = 1'b1;
      bar_wdata = word;
    end else if (cap_r && cap_line_r == LINE_SDRAP_LAST) begin
      bar1_wr   = 1'b1;
      bar_wdata = word;
    end else if (acc_wr && cfg_addr_i == OFS_REGAP_BASE) begin
      bar0_wr = 1'b1;
    end else if (acc_wr && cfg_addr_i == OFS_SDRAP_BASE) begin
      bar1_wr = 1'b1;
    end
  end

  // two base registers only
  hab_base_reg u_regap (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (bar0_wr),
    .wdata_i    (bar_wdata),
    .mask_i     (REGAP_MASK),
    .base_o     (bar0_q)
  );

  hab_base_reg u_sdrap (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .wr_i       (bar1_wr),
    .wdata_i    (bar_wdata),
    .mask_i     (sdrap_mask),
    .base_o     (bar1_q)
  );

  // boot sequencer
  always_comb begin
    state_nxt    = state_r;
    line_nxt     = line_r;
    last_nxt     = last_r;
    cfg_nxt      = cfg_r;
    cap_nxt      = 1'b0;
    cap_line_nxt = cap_line_r;
    hwy_nxt      = hwy_r;
    ready_nxt    = ready_r;
    unique case (state_r)
      HAB_IDLE: begin
        line_nxt  = LINE_MEM_SIZE;
        last_nxt  = LINE_BOOT_TYPE;
        state_nxt = HAB_READ;
      end
      HAB_READ: begin
        if (ee_ack_i) begin
          cap_nxt      = 1'b1;
          cap_line_nxt = line_r;
          unique case (line_r)
            LINE_MEM_SIZE: begin
              cfg_nxt.rows_256      = ee_data_i[ROWS_BIT];
              cfg_nxt.mem_size_code = ee_data_i[SIZE_CODE_LSB +: 3];
            end
            LINE_PLL: begin
              cfg_nxt.clock_multiplier_settings = ee_data_i;
            end
            LINE_BOOT_TYPE: begin
              cfg_nxt.autonomous = ee_data_i[BOOT_TYPE_BIT];
              if (ee_data_i[BOOT_TYPE_BIT]) begin
                last_nxt = LINE_SDRAP_LAST;
              end
            end
            default: begin
            end
          endcase
          state_nxt = HAB_NEXT;
        end
      end
      HAB_NEXT: begin
        // one idle cycle lets the assembled word settle before capture
        if (line_r == last_r) begin
          state_nxt = HAB_PLL_WAIT;
        end else begin
          line_nxt  = line_r + 11'h001;
          state_nxt = HAB_READ;
        end
      end
      HAB_PLL_WAIT: begin
        if (lock_s2_r) begin
          hwy_nxt   = 1'b1;
          ready_nxt = 1'b1;
          state_nxt = HAB_READY;
        end
      end
      HAB_READY: begin
      end
      default: begin
        state_nxt = HAB_IDLE;
      end
    endcase
    if (cap_r && cap_line_r == LINE_SUBSYS_LAST) begin
      cfg_nxt.subsystem_ids = word;
    end
    if (cap_r && cap_line_r == LINE_MMCFG_LAST) begin
      cfg_nxt.memory_config_word = word[19:0];
    end
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r    <= HAB_IDLE;
      line_r     <= LINE_MEM_SIZE;
      last_r     <= LINE_BOOT_TYPE;
      cap_r      <= 1'b0;
      cap_line_r <= LINE_MEM_SIZE;
    end else begin
      state_r    <= state_nxt;
      line_r     <= line_nxt;
      last_r     <= last_nxt;
      cap_r      <= cap_nxt;
      cap_line_r <= cap_line_nxt;
    end
  end

  // loaded settings
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= '{SUBSYS_RESET, MMCFG_RESET, PLL_RESET, 1'b0, 3'h0, 1'b0};
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // highway, memory interface and port enables rise together once lock is seen
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hwy_r   <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      hwy_r   <= hwy_nxt;
      ready_r <= ready_nxt;
    end
  end

  // control register: clearing the run bit puts the core back into reset
  always_comb begin
    run_nxt = run_r;
    if (acc_wr && cfg_addr_i == OFS_BUS_IF_CTRL) begin
      run_nxt = cfg_wdata_i[CORE_RUN_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
    end
  end

  // read answer stands one cycle and is zero otherwise
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (acc_rd) begin
      unique case (cfg_addr_i)
        OFS_REGAP_BASE:  rdata_nxt = bar0_q;
        OFS_SDRAP_BASE:  rdata_nxt = bar1_q;
        OFS_SUBSYS:      rdata_nxt = cfg_r.subsystem_ids;
        OFS_BUS_IF_CTRL: rdata_nxt = {31'h0, run_r};
        OFS_BOOT_STATUS: rdata_nxt = {28'h0000000, run_r, lock_s2_r, cfg_r.autonomous, ready_r};
        default:         rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign ee_req_o                 = (state_r == HAB_READ);
  assign ee_addr_o                = line_r;
  assign cfg_rdata_o              = rdata_r;
  assign boot_cfg_o               = cfg_r;
  assign highway_en_o             = hwy_r;
  assign mem_if_en_o              = hwy_r;
  assign core_reset_o             = !run_r;
  assign cfg_ready_o              = ready_r;
  assign serial_release_o         = ready_r;
  assign register_aperture_base_o = bar0_q;
  assign sdram_aperture_base_o    = bar1_q;

endmodule : hab_boot
`default_nettype wire

/* File: rtl/hab_byte_asm.sv */
// assembles consecutive eeprom bytes into a word, most significant first
`timescale 1ns/1ps
`default_nettype none
module hab_byte_asm (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        push_i,
  input  wire logic [7:0]  byte_i,
  output logic      [31:0] word_o
);
  logic [31:0] word_r;
  logic [31:0] word_nxt;

  // no word alignment assumed: every byte shifts in
  always_comb begin
    word_nxt = push_i ? {word_r[23:0], byte_i} : word_r;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_r <= 32'h00000000;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign word_o = word_r;
endmodule : hab_byte_asm
`default_nettype wire

/* File: rtl/hab_pkg.sv */
// shared constants and types of the host-assisted boot block
package hab_pkg;

  // eeprom line indices
  localparam logic [10:0] LINE_MEM_SIZE   = 11'h000;
  localparam logic [10:0] LINE_SUBSYS_LAST = 11'h004;
  localparam logic [10:0] LINE_MMCFG_LAST  = 11'h007;
  localparam logic [10:0] LINE_PLL         = 11'h008;
  localparam logic [10:0] LINE_BOOT_TYPE   = 11'h009;
  localparam logic [10:0] LINE_REGAP_LAST  = 11'h012;
  localparam logic [10:0] LINE_SDRAP_LAST  = 11'h01A;

  // line 0 and line 9 field positions
  localparam int ROWS_BIT      = 7;
  localparam int SIZE_CODE_LSB = 4;
  localparam int BOOT_TYPE_BIT = 7;

  // register offsets on the configuration port
  localparam logic [7:0] OFS_REGAP_BASE  = 8'h10;
  localparam logic [7:0] OFS_SDRAP_BASE  = 8'h14;
  localparam logic [7:0] OFS_SUBSYS      = 8'h2C;
  localparam logic [7:0] OFS_BUS_IF_CTRL = 8'h40;
  localparam logic [7:0] OFS_BOOT_STATUS = 8'h44;

  localparam int CORE_RUN_BIT = 0;

  // aperture masks: 2 MB register aperture, sdram from 1 MB upward
  localparam logic [31:0] REGAP_MASK     = 32'hFFE00000;
  localparam logic [31:0] SDRAP_MASK_1MB = 32'hFFF00000;
  localparam logic [2:0]  SIZE_CODE_MAX  = 3'h7;

  localparam logic [31:0] BASE_RESET   = 32'h00000000;
  localparam logic [19:0] MMCFG_RESET  = 20'h00000;
  localparam logic [7:0]  PLL_RESET    = 8'h00;
  localparam logic [31:0] SUBSYS_RESET = 32'h00000000;

  typedef enum logic [2:0] {
    HAB_IDLE     = 3'b000,
    HAB_READ     = 3'b001,
    HAB_NEXT     = 3'b010,
    HAB_PLL_WAIT = 3'b011,
    HAB_READY    = 3'b100
  } hab_state_e;

  typedef struct packed {
    logic [31:0] subsystem_ids;
    logic [19:0] memory_config_word;
    logic [7:0]  clock_multiplier_settings;
    logic        rows_256;
    logic [2:0]  mem_size_code;
    logic        autonomous;
  } hab_boot_cfg_s;

endpackage : hab_pkg

/* File: tb/hab_boot_bench.sv */
// testbench of the boot block acting as host
`timescale 1ns/1ps
`default_nettype none
module hab_boot_bench;
  import hab_pkg::*;
  logic          core_clk_i, nrst_i, ee_req_o, ee_ack_i, pll_lock_i;
  logic          cfg_wr_i, cfg_rd_i, highway_en_o, mem_if_en_o;
  logic          core_reset_o, cfg_ready_o, serial_release_o;
  logic [10:0]   ee_addr_o;
  logic [7:0]    ee_data_i, cfg_addr_i;
  logic [31:0]   cfg_wdata_i, cfg_rdata_o;
  logic [31:0]   register_aperture_base_o, sdram_aperture_base_o;
  logic [3:0]    dly;
  hab_boot_cfg_s boot_cfg_o;
  int            miscompares, comparisons;
  hab_boot dut (.core_clk_i, .nrst_i, .ee_req_o, .ee_addr_o, .ee_ack_i, .ee_data_i, .pll_lock_i,
    .cfg_addr_i, .cfg_wdata_i, .cfg_wr_i, .cfg_rd_i, .cfg_rdata_o, .boot_cfg_o, .highway_en_o,
    .mem_if_en_o, .core_reset_o, .cfg_ready_o, .serial_release_o, .register_aperture_base_o,
    .sdram_aperture_base_o);
  hab_ee_model ee (.core_clk_i, .nrst_i, .req_i(ee_req_o), .addr_i(ee_addr_o), .dly_i(dly),
    .ack_o(ee_ack_i), .data_o(ee_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge core_clk_i);
    cfg_rd_i <= 1'b0;
    #1 chk("read data", cfg_rdata_o, e);
  endtask : rd
  // reset, let stage one run, lock the pll late and wait for the port to open
  task automatic boot(input logic [7:0] l9);
    int i;
    ee.mem[9] = l9;
    nrst_i <= 1'b0;
    pll_lock_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (i = 0; i < 600 && cfg_ready_o !== 1'b1; i++) begin
      @(posedge core_clk_i);
      // a run-bit write before stage one ends must be refused
      cfg_wr_i    <= (i == 100);
      cfg_addr_i  <= OFS_BUS_IF_CTRL;
      cfg_wdata_i <= 32'h00000001;
      if (i == 200) pll_lock_i <= 1'b1;
      #1;
      if (i == 200) begin
        chk("ready before lock", cfg_ready_o, 32'h0);
        chk("core reset", core_reset_o, 32'h1);
      end
    end
    if (i == 600) begin
      miscompares++;
      stop_test();
    end
  endtask : boot
  initial begin
    {cfg_wr_i, cfg_rd_i} = 2'h0;
    cfg_addr_i = 8'h00;
    cfg_wdata_i = 32'h0;
    dly = 4'h0;
    miscompares = 0;
    comparisons = 0;
    for (int k = 0; k < 32; k++) ee.mem[k] = 8'h00;
    {ee.mem[1], ee.mem[2], ee.mem[3], ee.mem[4]} = 32'h12345678;
    {ee.mem[5], ee.mem[6], ee.mem[7], ee.mem[8]} = 32'hA9BCDE5A;
    for (int c = 0; c < 8; c++) begin
      ee.mem[0] = {1'b1, c[2:0], 4'h0};
      dly = c[3:0];
      boot(8'h00);
      chk("size code", boot_cfg_o.mem_size_code, c[2:0]);
      wr(OFS_SDRAP_BASE, 32'hFFFFFFFF);
      rd(OFS_SDRAP_BASE, ~((32'h00100000 << ((c < 2) ? 0 : c - 1)) - 32'h00000001));
      chk("last line", ee.maxa, 32'h9);
    end
    $display("sizing test done");
    chk("subsystem", boot_cfg_o.subsystem_ids, 32'h12345678);
    rd(OFS_SUBSYS, 32'h12345678);
    chk("mem config", boot_cfg_o.memory_config_word, 20'h9BCDE);
    chk("pll", boot_cfg_o.clock_multiplier_settings, 8'h5A);
    chk("rows", boot_cfg_o.rows_256, 1'b1);
    chk("enables", {highway_en_o, mem_if_en_o, serial_release_o}, 3'h7);
    wr(OFS_REGAP_BASE, 32'hFFFFFFFF);
    rd(OFS_REGAP_BASE, 32'hFFE00000);
    wr(OFS_REGAP_BASE, 32'h12345678);
    rd(OFS_REGAP_BASE, 32'h12200000);
    chk("reg base", register_aperture_base_o, 32'h12200000);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h0);
    rd(OFS_BUS_IF_CTRL, 32'h0);
    chk("core reset", core_reset_o, 1'b1);
    wr(OFS_BUS_IF_CTRL, 32'h1);
    rd(OFS_BOOT_STATUS, 32'hD);
    chk("core run", core_reset_o, 1'b0);
    $display("host test done");
    ee.mem[0] = 8'h30;
    {ee.mem[15], ee.mem[16], ee.mem[17], ee.mem[18]} = 32'hABCDEF01;
    {ee.mem[23], ee.mem[24], ee.mem[25], ee.mem[26]} = 32'h87654321;
    boot(8'h80);
    chk("autonomous", boot_cfg_o.autonomous, 1'b1);
    chk("rows", boot_cfg_o.rows_256, 1'b0);
    chk("size code", boot_cfg_o.mem_size_code, 3'h3);
    rd(OFS_SDRAP_BASE, 32'h87400000);
    chk("reg base", register_aperture_base_o, 32'hABC00000);
    chk("sdram base", sdram_aperture_base_o, 32'h87400000);
    chk("last line", ee.maxa, 32'h1A);
    chk("core reset", core_reset_o, 1'b1);
    $display("autonomous test done");
    stop_test();
  end
endmodule : hab_boot_bench
bind hab_boot hab_boot_chk chk (.core_clk_i, .nrst_i, .ee_req_o, .ee_addr_o, .ee_ack_i, .pll_lock_i,
  .cfg_rd_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o, .boot_cfg_o, .highway_en_o, .mem_if_en_o,
  .core_reset_o, .cfg_ready_o,
  .serial_release_o, .register_aperture_base_o, .sdram_aperture_base_o);
`default_nettype wire

/* File: tb/hab_boot_chk.sv */
// port-level checker of the boot block
`timescale 1ns/1ps
`default_nettype none
module hab_boot_chk
  import hab_pkg::*;
(
  input wire logic                   core_clk_i,
  input wire logic                   nrst_i,
  input wire logic                   ee_req_o,
  input wire logic [10:0]            ee_addr_o,
  input wire logic                   ee_ack_i,
  input wire logic                   pll_lock_i,
  input wire logic                   cfg_rd_i,
  input wire logic                   cfg_wr_i,
  input wire logic [7:0]             cfg_addr_i,
  input wire logic [31:0]            cfg_wdata_i,
  input wire logic [31:0]            cfg_rdata_o,
  input wire hab_pkg::hab_boot_cfg_s boot_cfg_o,
  input wire logic                   highway_en_o,
  input wire logic                   mem_if_en_o,
  input wire logic                   core_reset_o,
  input wire logic                   cfg_ready_o,
  input wire logic                   serial_release_o,
  input wire logic [31:0]            register_aperture_base_o,
  input wire logic [31:0]            sdram_aperture_base_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  core_hold_a: assert property (!cfg_ready_o |-> core_reset_o)
    else $error("core out of reset before boot done");
  lock_first_a: assert property ($rose(cfg_ready_o) |-> $past(pll_lock_i, 2) && highway_en_o && mem_if_en_o)
    else $error("boot done without lock or enables");
  serial_free_a: assert property (serial_release_o == cfg_ready_o && !(serial_release_o && ee_req_o))
    else $error("serial release differs from ready or eeprom still in use");
  regap_align_a: assert property (cfg_ready_o && cfg_wr_i && cfg_addr_i == OFS_REGAP_BASE
    |=> register_aperture_base_o == ($past(cfg_wdata_i) & REGAP_MASK))
    else $error("register aperture base not the masked write");
  sdrap_align_a: assert property (cfg_ready_o && cfg_wr_i && cfg_addr_i == OFS_SDRAP_BASE && cfg_wdata_i == 32'hFFFFFFFF
    |=> sdram_aperture_base_o[31:26] == 6'h3F && sdram_aperture_base_o[19:0] == 20'h00000)
    else $error("sdram aperture size outside range");
  host_lines_a: assert property (ee_req_o && ee_addr_o > LINE_BOOT_TYPE |-> boot_cfg_o.autonomous)
    else $error("line beyond nine read in host mode");
  line_limit_a: assert property (ee_req_o |-> ee_addr_o <= LINE_SDRAP_LAST)
    else $error("line beyond last one requested");
  line_step_a: assert property (ee_req_o && ee_ack_i && ee_addr_o < LINE_BOOT_TYPE
    |=> !ee_req_o ##1 ee_req_o && ee_addr_o == $past(ee_addr_o, 2) + 11'h001)
    else $error("next line not requested in order");
  rd_idle_a: assert property (!cfg_rd_i |=> cfg_rdata_o == 32'h0)
    else $error("read data outside read answer");
  cover property ($rose(cfg_ready_o));
  cover property (ee_req_o && ee_addr_o == LINE_SDRAP_LAST);
  cover property ($fell(core_reset_o));
endmodule : hab_boot_chk
`default_nettype wire

/* File: tb/hab_ee_model.sv */
// serial boot eeprom byte reader model with adjustable answer delay
`timescale 1ns/1ps
`default_nettype none
module hab_ee_model (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        req_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [3:0]  dly_i,
  output var  logic        ack_o,
  output var  logic [7:0]  data_o
);
  logic [7:0]  mem [0:31];
  logic [3:0]  cnt;
  logic [10:0] maxa;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o  <= 1'b0;
      data_o <= 8'hA5;
      cnt    <= 4'h0;
      maxa   <= 11'h000;
    end else if (req_i && !ack_o && cnt < dly_i) begin
      cnt    <= cnt + 4'h1;
      data_o <= ~data_o;
    end else if (req_i && !ack_o) begin
      // one byte per line, handed over in a single-cycle pulse
      ack_o  <= 1'b1;
      data_o <= mem[addr_i[4:0]];
      cnt    <= 4'h0;
      if (addr_i > maxa) maxa <= addr_i;
    end else begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule : hab_ee_model
`default_nettype wire
